// ### hdl/rsm_core.sv
// Reset state manager with classic Wishbone register slave
module rsm_core #(
    parameter int unsigned SLOW_DIV = 4
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire rsm_pkg::rsm_wb_req_t wb_req,
    output logic                      wb_ack,
    output logic [31:0]               wb_dat_o,
    input  wire logic                 bod_request,
    input  wire logic                 bod_rst_en,
    input  wire logic                 wdog_fault,
    input  wire logic                 wdog_cpu_only,
    input  wire logic                 wdog_reset_enable,
    input  wire logic                 pin_in,
    output logic                      pin_out,
    output logic                      pin_oe_n,
    output logic                      cpu_reset,
    output logic                      periph_reset,
    output logic                      irq
);

    rsm_pkg::rsm_regs_t               r;
    rsm_pkg::rsm_regs_t               next_r;
    rsm_pkg::rsm_state_t              nst;
    logic                             req;
    logic                             wr;
    logic                             rd;
    logic                             key_ok;
    logic                             cmd_go;
    logic [2:0]                       cmd;
    logic                             brown;
    logic                             wdg;
    logic                             user_low;
    logic                             pin_fall;
    logic                             bod_rise;
    logic                             drive;
    logic [rsm_pkg::PULSE_W-1:0]      pulse_len;
    logic [31:0]                      sr;
    logic [31:0]                      mr;

    // Next-state logic
    always_comb begin
        next_r = r;
        nst = r.state;

        // Two-flop synchronisers for pins
        next_r.bod_s1 = bod_request;
        next_r.bod_s2 = r.bod_s1;
        next_r.bod_prev = r.bod_s2;
        next_r.ben_s1 = bod_rst_en;
        next_r.ben_s2 = r.ben_s1;
        next_r.pin_s1 = pin_in;
        next_r.pin_s2 = r.pin_s1;
        next_r.pin_prev = r.pin_s2;

        // Slow tick from master clock
        next_r.tick = 1'b0;
        if (r.div_cnt == rsm_pkg::DIV_W'(SLOW_DIV - 1)) begin
            next_r.div_cnt = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.div_cnt = r.div_cnt + rsm_pkg::DIV_W'(1);
        end

        // Bus decode, one ack per request
        req = wb_req.cyc & wb_req.stb & ~r.ack;
        next_r.ack = req;
        wr = req & wb_req.we & (wb_req.sel == 4'hF);
        rd = req & ~wb_req.we;
        key_ok = wb_req.dat[rsm_pkg::KEY_LSB +: 8] == rsm_pkg::KEY_VALUE;
        cmd[0] = wb_req.dat[rsm_pkg::CMD_CPU];
        cmd[1] = wb_req.dat[rsm_pkg::CMD_PERIPH];
        cmd[2] = wb_req.dat[rsm_pkg::CMD_PIN];

        // Command taken when idle, keyed, not busy
        cmd_go = wr & (wb_req.adr == rsm_pkg::ADR_COMMAND) & key_ok
                 & ~r.busy & (cmd != 3'h0)
                 & (r.state == rsm_pkg::RSM_IDLE);

        // Status and mode read images
        sr = '0;
        sr[rsm_pkg::STAT_PIN_EVT] = r.pin_flag;
        sr[rsm_pkg::STAT_BOD] = r.bod_flag;
        sr[rsm_pkg::STAT_TYPE_LSB +: 3] = r.last_type;
        sr[rsm_pkg::STAT_PIN_LVL] = r.pin_s2;
        sr[rsm_pkg::STAT_BUSY] = r.busy;
        mr = '0;
        mr[rsm_pkg::MD_PIN_RST_EN] = r.ures_en;
        mr[rsm_pkg::MD_PIN_IRQ_EN] = r.uirq_en;
        mr[rsm_pkg::MD_LEN_LSB +: 4] = r.plen;
        mr[rsm_pkg::MD_BOD_IRQ_EN] = r.birq_en;

        // Read data, unmapped zero
        next_r.rdata = '0;
        if (rd) begin
            case (wb_req.adr)
                rsm_pkg::ADR_STATUS: begin
                    next_r.rdata = sr;
                end
                rsm_pkg::ADR_MODE: begin
                    next_r.rdata = mr;
                end
                default: begin
                    next_r.rdata = '0;
                end
            endcase
        end

        // Mode write under key
        if (wr & (wb_req.adr == rsm_pkg::ADR_MODE) & key_ok) begin
            next_r.ures_en = wb_req.dat[rsm_pkg::MD_PIN_RST_EN];
            next_r.uirq_en = wb_req.dat[rsm_pkg::MD_PIN_IRQ_EN];
            next_r.plen = wb_req.dat[rsm_pkg::MD_LEN_LSB +: 4];
            next_r.birq_en = wb_req.dat[rsm_pkg::MD_BOD_IRQ_EN];
        end

        // Sticky flags, set wins over read clear
        pin_fall = r.pin_prev & ~r.pin_s2;
        bod_rise = r.bod_s2 & ~r.bod_prev;
        if (rd & (wb_req.adr == rsm_pkg::ADR_STATUS)) begin
            next_r.pin_flag = 1'b0;
            next_r.bod_flag = 1'b0;
        end
        if (pin_fall) begin
            next_r.pin_flag = 1'b1;
        end
        if (bod_rise & ~r.ben_s2) begin
            next_r.bod_flag = 1'b1;
        end

        // Interrupt
        next_r.irq = (next_r.pin_flag & r.uirq_en & ~r.ures_en)
                     | (next_r.bod_flag & r.birq_en);

        // Reset sources
        brown = r.bod_s2 & r.ben_s2;
        wdg = wdog_fault & wdog_reset_enable;
        user_low = ~r.pin_s2 & r.ures_en & ~r.own_low;

        // Programmed pin pulse length
        pulse_len = rsm_pkg::PULSE_W'(1) << ({1'b0, r.plen} + 5'h01);

        // Pulse countdown per tick
        if (r.tick & (r.pulse != '0)) begin
            next_r.pulse = r.pulse - rsm_pkg::PULSE_W'(1);
        end

        // Source arbitration per state
        case (r.state)
            rsm_pkg::RSM_IDLE: begin
                if (brown) begin
                    nst = rsm_pkg::RSM_BROWN;
                end else if (wdg) begin
                    nst = rsm_pkg::RSM_WDOG;
                end else if (cmd_go) begin
                    nst = rsm_pkg::RSM_SOFT;
                end else if (user_low) begin
                    nst = rsm_pkg::RSM_USER;
                end
            end
            rsm_pkg::RSM_BROWN: begin
                if (brown) begin
                    next_r.hold = rsm_pkg::RESYNC_TICKS + rsm_pkg::LEAVE_TICKS;
                end else if (r.tick) begin
                    if (r.hold == 3'h1) begin
                        nst = rsm_pkg::RSM_IDLE;
                    end else begin
                        next_r.hold = r.hold - 3'h1;
                    end
                end
            end
            rsm_pkg::RSM_WDOG: begin
                // Pin activity not looked at here
                if (brown) begin
                    nst = rsm_pkg::RSM_BROWN;
                end else if (r.tick) begin
                    if (r.hold == 3'h1) begin
                        nst = rsm_pkg::RSM_IDLE;
                    end else begin
                        next_r.hold = r.hold - 3'h1;
                    end
                end
            end
            rsm_pkg::RSM_SOFT: begin
                if (brown) begin
                    nst = rsm_pkg::RSM_BROWN;
                end else if (wdg) begin
                    nst = rsm_pkg::RSM_WDOG;
                end else if (r.tick) begin
                    if (r.hold == 3'h1) begin
                        nst = rsm_pkg::RSM_IDLE;
                    end else begin
                        next_r.hold = r.hold - 3'h1;
                    end
                end
            end
            rsm_pkg::RSM_USER: begin
                if (brown) begin
                    nst = rsm_pkg::RSM_BROWN;
                end else if (wdg) begin
                    nst = rsm_pkg::RSM_WDOG;
                end else if (~r.pin_s2) begin
                    next_r.hold = rsm_pkg::RESYNC_TICKS + rsm_pkg::LEAVE_TICKS;
                end else if (r.tick) begin
                    if (r.hold == 3'h1) begin
                        nst = rsm_pkg::RSM_IDLE;
                    end else begin
                        next_r.hold = r.hold - 3'h1;
                    end
                end
            end
            default: begin
                nst = rsm_pkg::RSM_IDLE;
            end
        endcase

        // Entry actions
        if (nst != r.state) begin
            case (nst)
                rsm_pkg::RSM_BROWN: begin
                    next_r.hold = rsm_pkg::RESYNC_TICKS + rsm_pkg::LEAVE_TICKS;
                    next_r.cpu_rst = 1'b1;
                    next_r.per_rst = 1'b1;
                    next_r.busy = 1'b0;
                    next_r.pend_type = rsm_pkg::TYPE_BROWN;
                end
                rsm_pkg::RSM_WDOG: begin
                    next_r.hold = rsm_pkg::WDOG_TICKS;
                    next_r.cpu_rst = 1'b1;
                    next_r.per_rst = ~wdog_cpu_only;
                    if (~wdog_cpu_only) begin
                        next_r.pulse = pulse_len;
                    end
                    next_r.busy = 1'b0;
                    next_r.pend_type = rsm_pkg::TYPE_WDOG;
                end
                rsm_pkg::RSM_SOFT: begin
                    next_r.hold = rsm_pkg::SOFT_TICKS;
                    next_r.cpu_rst = cmd[0];
                    next_r.per_rst = cmd[1];
                    if (cmd[2]) begin
                        next_r.pulse = pulse_len;
                    end
                    next_r.busy = 1'b1;
                    next_r.pend_type = rsm_pkg::TYPE_SOFT;
                end
                rsm_pkg::RSM_USER: begin
                    next_r.hold = rsm_pkg::RESYNC_TICKS + rsm_pkg::LEAVE_TICKS;
                    next_r.cpu_rst = 1'b1;
                    next_r.per_rst = 1'b1;
                    next_r.pend_type = rsm_pkg::TYPE_USER;
                end
                rsm_pkg::RSM_IDLE: begin
                    next_r.cpu_rst = 1'b0;
                    next_r.per_rst = 1'b0;
                    next_r.busy = 1'b0;
                    if (r.cpu_rst) begin
                        next_r.last_type = r.pend_type;
                    end
                    if (r.state == rsm_pkg::RSM_BROWN) begin
                        next_r.pulse = pulse_len;
                    end
                end
                default: begin
                    next_r.cpu_rst = 1'b0;
                    next_r.per_rst = 1'b0;
                end
            endcase
        end
        next_r.state = nst;

        // Pin drive and own-pulse masking
        drive = (next_r.pulse != '0) | (nst == rsm_pkg::RSM_BROWN);
        next_r.pin_out = 1'b0;
        next_r.pin_oe_n = ~drive;
        next_r.own_low = drive | (r.own_low & ~r.pin_s2);

        // Synchronous reset to power-up values
        if (reset) begin
            next_r = '0;
            next_r.state = rsm_pkg::RSM_IDLE;
            next_r.last_type = rsm_pkg::TYPE_POWERUP;
            next_r.pin_s1 = 1'b1;
            next_r.pin_s2 = 1'b1;
            next_r.pin_prev = 1'b1;
            next_r.pin_oe_n = 1'b1;
            next_r.ures_en = rsm_pkg::MODE_RESET[rsm_pkg::MD_PIN_RST_EN];
            next_r.uirq_en = rsm_pkg::MODE_RESET[rsm_pkg::MD_PIN_IRQ_EN];
            next_r.plen = rsm_pkg::MODE_RESET[rsm_pkg::MD_LEN_LSB +: 4];
            next_r.birq_en = rsm_pkg::MODE_RESET[rsm_pkg::MD_BOD_IRQ_EN];
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        r <= next_r;
    end

    // Outputs straight from flops
    assign wb_ack       = r.ack;
    assign wb_dat_o     = r.rdata;
    assign pin_out      = r.pin_out;
    assign pin_oe_n     = r.pin_oe_n;
    assign cpu_reset    = r.cpu_rst;
    assign periph_reset = r.per_rst;
    assign irq          = r.irq;

endmodule

// ### hdl/rsm_pkg.sv
// Constants and types for the reset state manager
// How it works
// - Brownout request enters brownout, asserts all resets
// - Brownout ends 2+3 ticks later, pulses pin
// - Brownout release records reset type 5
// - Command bit 0 resets processor and watchdog
// - Command bit 2 resets all peripherals
// - Command bit 3 drives pin low programmed time
// - Any command enters software state, 3 ticks
// - Resets assert at write, release on tick
// - Own pin pulse never causes user reset
// - Type records software only with processor bit
// - Busy flag set by command, blocks command writes
// - Watchdog fault enters watchdog state, 3 ticks
// - Watchdog option selects processor-only or full
// - Watchdog disabled means faults are ignored
// - Priority: power-up, brownout, watchdog, software, user
// - In software state watchdog preempts, pin ignored
// - Watchdog state never enters user reset
// - Pin level bit sampled every master clock
// - Pin falling edge sets sticky flag, interrupt only with pin reset off
// - Brownout without reset sets flag, interrupt
// - Commands need correct key in write
// - Key bits 31:24 equal A5, else discarded
// - Pin pulse lasts 2^(length+1) slow ticks
// - Type codes software 3, watchdog 2, read-stable
package rsm_pkg;
    // Register byte offsets
    localparam logic [7:0]  ADR_COMMAND   = 8'h00;
    localparam logic [7:0]  ADR_STATUS    = 8'h04;
    localparam logic [7:0]  ADR_MODE      = 8'h08;
    // Key field
    localparam int          KEY_LSB       = 24;
    localparam logic [7:0]  KEY_VALUE     = 8'hA5;
    // Command bits
    localparam int          CMD_CPU       = 0;
    localparam int          CMD_PERIPH    = 2;
    localparam int          CMD_PIN       = 3;
    // Status fields
    localparam int          STAT_PIN_EVT  = 0;
    localparam int          STAT_BOD      = 1;
    localparam int          STAT_TYPE_LSB = 8;
    localparam int          STAT_PIN_LVL  = 16;
    localparam int          STAT_BUSY     = 17;
    // Mode fields
    localparam int          MD_PIN_RST_EN = 0;
    localparam int          MD_PIN_IRQ_EN = 4;
    localparam int          MD_LEN_LSB    = 8;
    localparam int          MD_BOD_IRQ_EN = 16;
    localparam logic [31:0] MODE_RESET    = 32'h0000_0000;
    // Last reset type codes
    localparam logic [2:0]  TYPE_POWERUP  = 3'h0;
    localparam logic [2:0]  TYPE_WDOG     = 3'h2;
    localparam logic [2:0]  TYPE_SOFT     = 3'h3;
    localparam logic [2:0]  TYPE_USER     = 3'h4;
    localparam logic [2:0]  TYPE_BROWN    = 3'h5;
    // Slow clock tick counts
    localparam logic [2:0]  RESYNC_TICKS  = 3'h2;
    localparam logic [2:0]  LEAVE_TICKS   = 3'h3;
    localparam logic [2:0]  SOFT_TICKS    = 3'h3;
    localparam logic [2:0]  WDOG_TICKS    = 3'h3;
    // Counter widths
    localparam int          DIV_W         = 16;
    localparam int          PULSE_W       = 17;

    typedef enum logic [2:0] {
        RSM_IDLE,
        RSM_BROWN,
        RSM_WDOG,
        RSM_SOFT,
        RSM_USER
    } rsm_state_t;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } rsm_wb_req_t;

    // Whole state of the manager
    typedef struct packed {
        rsm_state_t           state;
        logic [DIV_W-1:0]     div_cnt;
        logic                 tick;
        logic [2:0]           hold;
        logic                 bod_s1;
        logic                 bod_s2;
        logic                 bod_prev;
        logic                 ben_s1;
        logic                 ben_s2;
        logic                 pin_s1;
        logic                 pin_s2;
        logic                 pin_prev;
        logic                 own_low;
        logic [PULSE_W-1:0]   pulse;
        logic                 busy;
        logic [2:0]           pend_type;
        logic [2:0]           last_type;
        logic                 pin_flag;
        logic                 bod_flag;
        logic                 ures_en;
        logic                 uirq_en;
        logic [3:0]           plen;
        logic                 birq_en;
        logic                 cpu_rst;
        logic                 per_rst;
        logic                 pin_out;
        logic                 pin_oe_n;
        logic                 irq;
        logic                 ack;
        logic [31:0]          rdata;
    } rsm_regs_t;
endpackage

// ### test/rsm_core_sva.sv
// Port checker, reset state manager
module rsm_core_sva #(
    parameter int unsigned SLOW_DIV = 4
) (
    input wire logic                 ref_clk,
    input wire logic                 reset,
    input wire rsm_pkg::rsm_wb_req_t wb_req,
    input wire logic                 wb_ack,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 bod_request,
    input wire logic                 bod_rst_en,
    input wire logic                 wdog_fault,
    input wire logic                 wdog_cpu_only,
    input wire logic                 wdog_reset_enable,
    input wire logic                 pin_in,
    input wire logic                 pin_out,
    input wire logic                 pin_oe_n,
    input wire logic                 cpu_reset,
    input wire logic                 periph_reset,
    input wire logic                 irq
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BLO = 4 * SLOW_DIV;
    localparam int BW  = SLOW_DIV + 6;
    logic        cmd_ok;
    logic [15:0] hi_cnt;
    logic        short_kind;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // Keyed command write offered
    assign cmd_ok = wb_req.cyc && wb_req.stb && wb_req.we && !wb_ack && wb_req.adr == 8'h00
                    && wb_req.sel == 4'hF && wb_req.dat[31:24] == rsm_pkg::KEY_VALUE;
    // Reset length, short-state cause
    always_ff @(posedge ref_clk) begin
        hi_cnt     <= (reset || !cpu_reset) ? 16'h0000 : hi_cnt + 16'h0001;
        short_kind <= cpu_reset ? short_kind : (wdog_fault && wdog_reset_enable) || (cmd_ok && wb_req.dat[0]);
    end
    a_ack_pulse: assert property (wb_ack |=> !wb_ack) else $error("ack long");
    a_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack) else $error("no answer");
    a_brown_enter: assert property ((bod_request && bod_rst_en) [*4] |-> cpu_reset && periph_reset && !pin_oe_n)
        else $error("brown resets");
    a_brown_leave: assert property ($fell(bod_request) && cpu_reset && bod_rst_en
        |-> (cpu_reset throughout ##BLO 1) ##[1:BW] !cpu_reset) else $error("brown leave");
    a_wdog_cpu: assert property (wdog_fault && wdog_reset_enable && wdog_cpu_only && !cpu_reset && !periph_reset
        |=> cpu_reset && !periph_reset) else $error("wdog cpu only");
    a_wdog_full: assert property (wdog_fault && wdog_reset_enable && !wdog_cpu_only && !cpu_reset
        |=> cpu_reset && periph_reset ##[0:1] !pin_oe_n) else $error("wdog full");
    a_short_len: assert property ($fell(cpu_reset) && short_kind
        |-> hi_cnt >= 2 * SLOW_DIV && hi_cnt <= 3 * SLOW_DIV + 1) else $error("state length");
    a_cpu_cause: assert property ($rose(cpu_reset) |-> $past(cmd_ok && wb_req.dat[0])
        || $past(wdog_fault && wdog_reset_enable) || $past(bod_request, 3) || $past(!pin_in, 3) || $past(!pin_in, 4))
        else $error("cpu cause");
    a_periph_cause: assert property ($rose(periph_reset) |-> $past(cmd_ok && wb_req.dat[2])
        || $past(wdog_fault && wdog_reset_enable && !wdog_cpu_only) || $past(bod_request, 3) || $past(!pin_in, 3)
        || $past(!pin_in, 4)) else $error("periph cause");
    a_pin_drive: assert property (!pin_oe_n |-> !pin_out) else $error("pin high");
    c_brown: cover property (cpu_reset && periph_reset && !pin_oe_n);
    c_cpu_only: cover property (cpu_reset && !periph_reset);
    c_irq: cover property ($rose(irq));
endmodule
bind rsm_core rsm_core_sva #(.SLOW_DIV(SLOW_DIV)) rsm_core_sva_i (.ref_clk(ref_clk), .reset(reset), .wb_req(wb_req),
    .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .bod_request(bod_request), .bod_rst_en(bod_rst_en), .wdog_fault(wdog_fault),
    .wdog_cpu_only(wdog_cpu_only), .wdog_reset_enable(wdog_reset_enable), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .cpu_reset(cpu_reset), .periph_reset(periph_reset), .irq(irq));

// ### test/rsm_pin_partner.sv
// Outside device sharing the pulled-up reset pin
module rsm_pin_partner (
    input  wire logic       ref_clk,
    input  wire logic       pin_out,
    input  wire logic       pin_oe_n,
    input  wire logic       press,
    input  wire logic [7:0] stretch,
    output logic            pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] keep = 8'h00;
    // Slow device holds line low after release
    always @(posedge ref_clk) begin
        keep <= !pin_oe_n ? stretch : (keep != 8'h00 ? keep - 8'h01 : 8'h00);
    end
    // Wired-and with pull-up
    assign pin_in = (pin_oe_n ? 1'b1 : pin_out) & !press & (keep == 8'h00);
endmodule

// ### test/testbench.sv
// Self-checking bench, reset state manager
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DIV = 4;
    logic                 ref_clk = 1'b0;
    logic                 reset = 1'b1;
    rsm_pkg::rsm_wb_req_t wb_req = '0;
    logic                 bod_request = 1'b0, bod_rst_en = 1'b1, wdog_fault = 1'b0, wdog_cpu_only = 1'b0;
    logic                 wdog_reset_enable = 1'b0, press = 1'b0, cpu_seen = 1'b0;
    logic                 wb_ack, pin_in, pin_out, pin_oe_n, cpu_reset, periph_reset, irq;
    logic [31:0]          wb_dat_o, rd;
    logic [15:0]          low_cnt = 16'h0000, last_low = 16'h0000;
    logic [7:0]           stretch = 8'h00;
    logic [2:0]           typ = 3'h0;
    logic [3:0]           cmds [5] = '{4'h1, 4'h4, 4'h8, 4'h5, 4'hD}; // Case with bits 0, 2 and 3 all set included
    int                   fails = 0, tests_run = 0, i;

    always #4 ref_clk = ~ref_clk;

    rsm_core #(.SLOW_DIV(DIV)) rsm_core_i (.ref_clk(ref_clk), .reset(reset), .wb_req(wb_req), .wb_ack(wb_ack),
        .wb_dat_o(wb_dat_o), .bod_request(bod_request), .bod_rst_en(bod_rst_en), .wdog_fault(wdog_fault),
        .wdog_cpu_only(wdog_cpu_only), .wdog_reset_enable(wdog_reset_enable), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .cpu_reset(cpu_reset), .periph_reset(periph_reset), .irq(irq));
    rsm_pin_partner rsm_pin_partner_i (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .press(press),
        .stretch(stretch), .pin_in(pin_in));

    // Own pulse length, cpu reset watch
    always @(posedge ref_clk) begin
        if (cpu_reset === 1'b1) cpu_seen <= 1'b1;
        if (pin_oe_n === 1'b0) low_cnt <= low_cnt + 16'h0001;
        else if (low_cnt != 16'h0000) begin
            last_low <= low_cnt;
            low_cnt  <= 16'h0000;
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Pulse 2^(len+1) ticks, first partial
    task automatic chk_len(input logic [15:0] got, input int len);
        int lo;
        lo = ((1 << (len + 1)) - 1) * DIV;
        tests_run++;
        if ((got > lo && got <= lo + DIV + 2) !== 1'b1) begin
            fails++;
            $display("unexpected %0t got %h exp %h", $time, got, lo + DIV);
        end
    endtask

    // Single cycle held until ack
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge ref_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: wr, adr: a, sel: 4'hF, dat: d};
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (wb_ack === 1'b1) break;
        end
        q = wb_dat_o;
        wb_req <= '0;
        if (n == 50) begin
            fails++;
            tally_and_finish();
        end
    endtask

    // Wait for quiet lines, read status
    task automatic settle();
        for (i = 0; i < 3000; i++) begin
            @(posedge ref_clk);
            if (cpu_reset === 1'b0 && periph_reset === 1'b0 && pin_oe_n === 1'b1 && pin_in === 1'b1) break;
        end
        if (i == 3000) begin
            fails++;
            tally_and_finish();
        end
        bus(1'b0, 8'h04, 32'h0, rd);
        chk(rd[17], 1'b0);
    endtask

    function automatic logic [2:0] exp_type(input logic [3:0] cmd, input logic [2:0] prev);
        return cmd[0] ? 3'h3 : prev;
    endfunction

    function automatic logic [7:0] bad_key();
        logic [7:0] r;
        r = 8'($urandom);
        return (r == 8'hA5) ? 8'h00 : r;
    endfunction

    initial begin
        void'($urandom(32'hA1DE));
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        // Reset values, unmapped
        bus(1'b0, 8'h04, 32'h0, rd);
        chk(rd, 32'h0001_0000);
        bus(1'b0, 8'h08, 32'h0, rd);
        chk(rd, rsm_pkg::MODE_RESET);
        bus(1'b1, 8'h0C, 32'hFFFF_FFFF, rd);
        bus(1'b0, 8'h0C, 32'h0, rd);
        chk(rd, 32'h0);
        // Wrong keys
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'h00, {bad_key(), 24'h00_000D}, rd);
            chk({cpu_reset, periph_reset, pin_oe_n}, 3'b001);
            bus(1'b1, 8'h08, {bad_key(), 24'h01_0111}, rd);
            bus(1'b0, 8'h08, 32'h0, rd);
            chk(rd, 32'h0);
        end
        bus(1'b1, 8'h08, 32'hA500_0111, rd);
        bus(1'b0, 8'h08, 32'h0, rd);
        chk(rd, 32'h0000_0111);
        $display("done: keys");
        // Five command values, second write while busy
        for (int k = 0; k < 5; k++) begin
            stretch <= 8'($urandom_range(20, 0));
            bus(1'b1, 8'h00, {8'hA5, 20'h0, cmds[k]}, rd);
            chk({cpu_reset, periph_reset}, {cmds[k][0], cmds[k][2]});
            bus(1'b1, 8'h00, 32'hA500_0005, rd);
            bus(1'b0, 8'h04, 32'h0, rd);
            chk({rd[17], cpu_reset, periph_reset}, {1'b1, cmds[k][0], cmds[k][2]});
            settle();
            typ = exp_type(cmds[k], typ);
            chk(rd[10:8], typ);
            if (cmds[k][3]) chk_len(last_low, 1);
            chk(cpu_seen, cmds[k][0]);
            cpu_seen <= 1'b0;
        end
        stretch <= 8'h00;
        $display("done: cmds");
        // Outside device holds pin
        press <= 1'b1;
        repeat (30) @(posedge ref_clk);
        bus(1'b0, 8'h04, 32'h0, rd);
        chk({rd[16], rd[0], cpu_reset, periph_reset}, 4'b0111);
        press <= 1'b0;
        settle();
        typ = 3'h4;
        chk(rd[10:8], typ);
        // Watchdog preempts pin-only command
        bus(1'b1, 8'h00, 32'hA500_0008, rd);
        press <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk(cpu_reset, 1'b0);
        press <= 1'b0;
        wdog_reset_enable <= 1'b1;
        wdog_fault <= 1'b1;
        @(posedge ref_clk);
        wdog_fault <= 1'b0;
        @(posedge ref_clk);
        chk({cpu_reset, periph_reset}, 2'b11);
        settle();
        typ = 3'h2;
        chk(rd[10:8], typ);
        $display("done: preempt");
        // Watchdog off, cpu only, full
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            wdog_reset_enable <= (k != 0);
            wdog_cpu_only <= (k == 1);
            wdog_fault <= 1'b1;
            @(posedge ref_clk);
            wdog_fault <= 1'b0;
            @(posedge ref_clk);
            chk({cpu_reset, periph_reset}, {k != 0, k == 2});
            settle();
            if (k == 2) chk_len(last_low, 1);
            chk(rd[10:8], typ);
        end
        // Brownout with watchdog fault inside
        bod_request <= 1'b1;
        repeat ($urandom_range(30, 8)) @(posedge ref_clk);
        wdog_fault <= 1'b1;
        @(posedge ref_clk);
        wdog_fault <= 1'b0;
        chk({cpu_reset, periph_reset, pin_oe_n}, 3'b110);
        bod_request <= 1'b0;
        settle();
        typ = 3'h5;
        chk(rd[10:8], typ);
        $display("done: brownout");
        // Pin event irq, pin reset off
        bus(1'b1, 8'h08, 32'hA501_0110, rd);
        cpu_seen <= 1'b0;
        press <= 1'b1;
        repeat (20) @(posedge ref_clk);
        press <= 1'b0;
        chk({cpu_seen, irq}, 2'b01);
        bus(1'b0, 8'h04, 32'h0, rd);
        @(posedge ref_clk);
        chk({rd[0], irq}, 2'b10);
        // Brownout reporting only
        bod_rst_en <= 1'b0;
        repeat (4) @(posedge ref_clk);
        bod_request <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk({cpu_reset, irq}, 2'b01);
        bod_request <= 1'b0;
        bus(1'b0, 8'h04, 32'h0, rd);
        @(posedge ref_clk);
        chk({rd[1], irq}, 2'b10);
        bus(1'b0, 8'h04, 32'h0, rd);
        chk({rd[1], rd[10:8]}, {1'b0, typ});
        $display("done: irq");
        tally_and_finish();
    end
endmodule
